// file: src/accel_serial_host.sv
// Serial host that reaches the accelerometer by two-wire or SPI
`timescale 1ns/1ns
module accel_serial_host import accel_link_pkg::*; (
   input  wire logic       clk,
   input  wire logic       arst_n,
   accel_link_if.host      link,
   input  wire logic       req_valid,
   output logic            req_ready,
   input  wire logic       req_read,
   input  wire logic       req_fast,
   input  wire logic       req_spi,
   input  wire logic [6:0] req_dev,
   input  wire logic [7:0] req_reg,
   input  wire logic [2:0] req_len,
   input  wire logic [7:0] wr_data,
   output logic            wr_take,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output logic            done,
   output logic            nack
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} hstate_t;
   typedef enum logic [2:0] {G_ADDRW, G_REG, G_DATAW, G_ADDRR, G_DATAR} stage_t;

   hstate_t    st_q, st_d;
   stage_t     stg_q, stg_d;
   logic [7:0] div_q, div_d, gap_q, gap_d, sh_q, sh_d, rd_q, rd_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] left_q, left_d;
   logic [6:0] dev_q, dev_d;
   logic       spi_q, spi_d, fast_q, fast_d, read_q, read_d, ack_q, ack_d;
   logic       scl_q, scl_d, sda_q, sda_d, cs_n_q, cs_n_d;
   logic       take_q, take_d, rv_q, rv_d, done_q, done_d, nack_q, nack_d;
   logic       meta_q, sync_q, tick, rx;

   // ----------------------------------------
   // Data line synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= link.sda;
         sync_q <= meta_q;
      end
   end

   assign tick = (div_q == 8'h00);
   assign rx   = (stg_q == G_DATAR);

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   always_comb begin
      st_d = st_q;   stg_d = stg_q;   div_d = div_q;   gap_d = gap_q;
      sh_d = sh_q;   rd_d = rd_q;     ph_d = ph_q;     bit_d = bit_q;
      left_d = left_q; dev_d = dev_q; spi_d = spi_q;   fast_d = fast_q;
      read_d = read_q; ack_d = ack_q; scl_d = scl_q;   sda_d = sda_q;
      cs_n_d = cs_n_q; nack_d = nack_q;
      take_d = 1'b0; rv_d = 1'b0; done_d = 1'b0;
      if (st_q != H_IDLE && st_q != H_GAP) begin
         div_d = tick ? (spi_q ? SPI_Q : (fast_q ? FAST_Q : STD_Q)) - 8'h01
                      : div_q - 8'h01;
         if (tick) begin
            ph_d = ph_q + 2'h1;
         end
      end
      unique case (st_q)
         H_IDLE: begin
            if (req_valid) begin
               spi_d = req_spi;  fast_d = req_fast; read_d = req_read;
               dev_d = req_dev;  left_d = req_len;  nack_d = 1'b0;
               div_d = 8'h00;    ph_d = 2'h0;       bit_d = 4'h0;
               if (req_spi) begin
                  cs_n_d = 1'b0;
                  st_d   = H_BIT;
                  stg_d  = G_REG;
                  sh_d   = {1'b0, req_len != 3'h0, req_reg[5:0]};
               end else begin
                  cs_n_d = 1'b1;
                  st_d   = H_START;
                  stg_d  = G_ADDRW;
                  sh_d   = {req_dev, 1'b0};
               end
            end
         end
         H_START: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: sda_d = 1'b1;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b0;
                  2'h3: begin
                     scl_d = 1'b0;
                     st_d  = H_BIT;
                     bit_d = 4'h0;
                  end
               endcase
            end
         end
         H_BIT: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: begin
                     scl_d = 1'b0;
                     if (bit_q == 4'h8) begin
                        sda_d = rx ? (left_q == 3'h0) : 1'b1;
                     end else begin
                        sda_d = rx ? 1'b1 : sh_q[7];
                     end
                  end
                  2'h1: scl_d = spi_q ? 1'b0 : 1'b1;
                  2'h2: begin
                     scl_d = 1'b1;
                     // Only the acknowledge bit is sampled while sending data
                     if (bit_q == 4'h8) begin
                        ack_d = sync_q;
                     end else if (rx) begin
                        sh_d = {sh_q[6:0], sync_q};
                     end
                  end
                  2'h3: begin
                     scl_d = spi_q;
                     bit_d = bit_q + 4'h1;
                     if (bit_q < 4'h8 && !rx) begin
                        sh_d = {sh_q[6:0], 1'b0};
                     end
                     if (bit_q == (spi_q ? 4'h7 : 4'h8)) begin
                        bit_d = 4'h0;
                        if (!spi_q && !rx && ack_q) begin
                           nack_d = 1'b1;
                           st_d   = H_STOP;
                        end else begin
                           unique case (stg_q)
                              G_ADDRW: begin
                                 stg_d = G_REG;
                                 sh_d  = req_reg;
                              end
                              G_REG: begin
                                 if (read_q && !spi_q) begin
                                    st_d  = H_START;
                                    stg_d = G_ADDRR;
                                    sh_d  = {dev_q, 1'b1};
                                 end else begin
                                    stg_d  = G_DATAW;
                                    sh_d   = wr_data;
                                    take_d = 1'b1;
                                 end
                              end
                              G_DATAW: begin
                                 if (left_q == 3'h0) begin
                                    st_d = spi_q ? H_GAP : H_STOP;
                                    if (spi_q) begin
                                       cs_n_d = 1'b1;
                                       gap_d  = CS_GAP_CYC;
                                    end
                                 end else begin
                                    left_d = left_q - 3'h1;
                                    sh_d   = wr_data;
                                    take_d = 1'b1;
                                 end
                              end
                              G_ADDRR: stg_d = G_DATAR;
                              G_DATAR: begin
                                 rd_d = sh_q;
                                 rv_d = 1'b1;
                                 if (left_q == 3'h0) begin
                                    st_d = H_STOP;
                                 end else begin
                                    left_d = left_q - 3'h1;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: sda_d = 1'b0;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b1;
                  2'h3: begin
                     st_d  = H_GAP;
                     gap_d = CS_GAP_CYC;
                  end
               endcase
            end
         end
         H_GAP: begin
            gap_d = gap_q - 8'h01;
            if (gap_q == 8'h01) begin
               st_d   = H_IDLE;
               done_d = 1'b1;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= H_IDLE;  stg_q <= G_ADDRW; div_q <= 8'h00; gap_q <= 8'h00;
         sh_q <= 8'h00;   rd_q <= 8'h00;    ph_q <= 2'h0;   bit_q <= 4'h0;
         left_q <= 3'h0;  dev_q <= 7'h00;   spi_q <= 1'b0;  fast_q <= 1'b0;
         read_q <= 1'b0;  ack_q <= 1'b0;    scl_q <= 1'b1;  sda_q <= 1'b1;
         cs_n_q <= 1'b1;  take_q <= 1'b0;   rv_q <= 1'b0;   done_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         st_q <= st_d;    stg_q <= stg_d;   div_q <= div_d; gap_q <= gap_d;
         sh_q <= sh_d;    rd_q <= rd_d;     ph_q <= ph_d;   bit_q <= bit_d;
         left_q <= left_d; dev_q <= dev_d;  spi_q <= spi_d; fast_q <= fast_d;
         read_q <= read_d; ack_q <= ack_d;  scl_q <= scl_d; sda_q <= sda_d;
         cs_n_q <= cs_n_d; take_q <= take_d; rv_q <= rv_d;  done_q <= done_d;
         nack_q <= nack_d;
      end
   end

   // ----------------------------------------
   // Pins and user outputs
   // ----------------------------------------
   // SPI drives push-pull at all times; two-wire only pulls low
   assign link.cs_n     = cs_n_q;
   assign link.scl_o    = scl_q;
   assign link.scl_oe   = spi_q | ~scl_q;
   assign link.h_sda_o  = sda_q;
   assign link.h_sda_oe = spi_q | ~sda_q;
   assign req_ready     = (st_q == H_IDLE);
   assign wr_take       = take_q;
   assign rd_data       = rd_q;
   assign rd_valid      = rv_q;
   assign done          = done_q;
   assign nack          = nack_q;

endmodule : accel_serial_host

// file: src/accel_link_pkg.sv
// Shared constants for the accelerometer serial link ends
package accel_link_pkg;

   // ----------------------------------------
   // Clock and link rates
   // ----------------------------------------
   localparam int CLK_HZ     = 10_000_000;
   localparam int CLK_NS     = 100;
   localparam int STD_HZ     = 100_000;
   localparam int FAST_HZ    = 400_000;
   localparam int ODR_MAX_HZ = 800;
   // Quarter bit periods round up so the bus never runs faster than the rate
   localparam logic [7:0] STD_Q  = 8'((CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
   localparam logic [7:0] FAST_Q = 8'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));

   // ----------------------------------------
   // SPI host timing
   // ----------------------------------------
   localparam int SCLK_MIN_NS   = 200;
   localparam int CS_GAP_NS     = 150;
   localparam logic [7:0] SPI_Q = 8'((SCLK_MIN_NS + 4 * CLK_NS - 1) / (4 * CLK_NS));
   localparam logic [7:0] CS_GAP_CYC = 8'((CS_GAP_NS + CLK_NS - 1) / CLK_NS);

   // ----------------------------------------
   // Slave addressing and register space
   // ----------------------------------------
   localparam logic [6:0] ADDR_SEL_HIGH = 7'h1D;
   localparam logic [6:0] ADDR_SEL_LOW  = 7'h53;
   localparam int         PTR_W         = 6;
   localparam int         REG_COUNT     = 64;
   localparam logic [7:0] REG_RESET     = 8'h00;

   function automatic logic [6:0] own_address(input logic sel);
      return sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
   endfunction : own_address

endpackage : accel_link_pkg

// file: src/accel_link_if.sv
// Pin bundle between the serial host and the accelerometer port
`timescale 1ns/1ns
interface accel_link_if;
   logic cs_n;
   logic scl_o;
   logic scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;

   // Pull-up wires: any enabled driver showing zero pulls the line low
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

   modport host   (output cs_n, scl_o, scl_oe, h_sda_o, h_sda_oe, input scl, sda);
   modport device (output d_sda_o, d_sda_oe, input cs_n, scl, sda);
endinterface : accel_link_if

// file: src/accel_slave_port.sv
// Two-wire slave port of the accelerometer with its register array
// Function
// - Two-wire slave only while chip select high
// - Works at standard and fast bus rates
// - Single and multi-byte reads and writes
// - Strap high answers address 0x1D
// - Strap low answers address 0x53
// - Host keeps data rate within bus limit
// - SPI chip select idle gap 150 ns
// - SPI clock period and duty limits
// - Host drives select, clock, data always; in two-wire mode clock and data only pull low
// - Device is slave only, never initiates
// - Master ignores device data during writes
// - Read phase uses repeated or new start
`timescale 1ns/1ns
module accel_slave_port import accel_link_pkg::*; (
   input  wire logic             clk,
   input  wire logic             arst_n,
   accel_link_if.device          link,
   input  wire logic             slave_address_select_pin,
   input  wire logic             local_we,
   input  wire logic [PTR_W-1:0] local_addr,
   input  wire logic [7:0]       local_wdata,
   output logic                  host_wr_stb,
   output logic [PTR_W-1:0]      host_wr_addr,
   output logic [7:0]            host_wr_data
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_END, S_ACK, S_TX, S_RACK} state_t;
   typedef enum logic [1:0] {P_ADDR, P_REG, P_DATA} phase_t;

   state_t           state_q, state_d;
   phase_t           phase_q, phase_d;
   logic [2:0]       cnt_q, cnt_d;
   logic [7:0]       shift_q, shift_d;
   logic [PTR_W-1:0] ptr_q, ptr_d;
   logic             rw_q, rw_d;
   logic             nack_q, nack_d;
   logic             oe_q, oe_d;
   logic             stb_q, stb_d;
   logic [PTR_W-1:0] waddr_q, waddr_d;
   logic [7:0]       wdata_q, wdata_d;
   logic [7:0]       mem [REG_COUNT];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Bits: 0 clock, 1 data, 2 chip select, 3 address strap
   logic [3:0] meta_q, sync_q, prev_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 4'hF;
         sync_q <= 4'hF;
         prev_q <= 4'hF;
      end else begin
         meta_q <= {slave_address_select_pin, link.cs_n, link.sda, link.scl};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   logic i2c_en, scl_rise, scl_fall, start_seen, stop_seen, sda_in;
   // Any low on chip select parks the two-wire engine
   assign i2c_en     = sync_q[2] & prev_q[2];
   assign sda_in     = sync_q[1];
   assign scl_rise   = sync_q[0] & ~prev_q[0];
   assign scl_fall   = ~sync_q[0] & prev_q[0];
   // Edge sampling at 10 MHz leaves several samples per fast-mode half bit
   assign start_seen = i2c_en & sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
   assign stop_seen  = i2c_en & sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      nack_d  = nack_q;
      oe_d    = oe_q;
      stb_d   = 1'b0;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      if (!i2c_en) begin
         state_d = S_IDLE;
         oe_d    = 1'b0;
      end else if (start_seen) begin
         // A repeated start restarts addressing and keeps the pointer
         state_d = S_RX;
         phase_d = P_ADDR;
         cnt_d   = 3'h0;
         oe_d    = 1'b0;
      end else if (stop_seen) begin
         state_d = S_IDLE;
         oe_d    = 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
            end
            S_RX: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_in};
                  cnt_d   = cnt_q + 3'h1;
                  if (cnt_q == 3'h7) begin
                     state_d = S_RX_END;
                  end
               end
            end
            S_RX_END: begin
               if (scl_fall) begin
                  state_d = S_ACK;
                  oe_d    = 1'b1;
                  unique case (phase_q)
                     P_ADDR: begin
                        if (shift_q[7:1] == own_address(sync_q[3])) begin
                           rw_d    = shift_q[0];
                           phase_d = P_REG;
                        end else begin
                           state_d = S_IDLE;
                           oe_d    = 1'b0;
                        end
                     end
                     P_REG: begin
                        // Register space is 64 entries; upper address bits wrap
                        ptr_d   = shift_q[PTR_W-1:0];
                        phase_d = P_DATA;
                     end
                     default: begin
                        stb_d   = 1'b1;
                        waddr_d = ptr_q;
                        wdata_d = shift_q;
                        ptr_d   = ptr_q + 1'b1;
                     end
                  endcase
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  cnt_d = 3'h0;
                  if (rw_q) begin
                     shift_d = mem[ptr_q];
                     oe_d    = ~mem[ptr_q][7];
                     state_d = S_TX;
                  end else begin
                     oe_d    = 1'b0;
                     state_d = S_RX;
                  end
               end
            end
            S_TX: begin
               // Data changes only after the clock falls, never while it is high
               if (scl_rise) begin
                  cnt_d = cnt_q + 3'h1;
               end else if (scl_fall) begin
                  if (cnt_q == 3'h0) begin
                     oe_d    = 1'b0;
                     state_d = S_RACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d    = ~shift_q[6];
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  nack_d = sda_in;
                  ptr_d  = ptr_q + 1'b1;
               end else if (scl_fall) begin
                  if (!nack_q) begin
                     shift_d = mem[ptr_q];
                     oe_d    = ~mem[ptr_q][7];
                     state_d = S_TX;
                  end else begin
                     state_d = S_IDLE;
                  end
               end
            end
            default: begin
               state_d = S_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= S_IDLE;
         phase_q <= P_ADDR;
         cnt_q   <= 3'h0;
         shift_q <= 8'h00;
         ptr_q   <= '0;
         rw_q    <= 1'b0;
         nack_q  <= 1'b0;
         oe_q    <= 1'b0;
         stb_q   <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         nack_q  <= nack_d;
         oe_q    <= oe_d;
         stb_q   <= stb_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
      end
   end

   // ----------------------------------------
   // Register array
   // ----------------------------------------
   // Host writes win over a same-cycle local update
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem[i] <= REG_RESET;
         end
      end else if (stb_d) begin
         mem[ptr_q] <= shift_q;
      end else if (local_we) begin
         mem[local_addr] <= local_wdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Open drain: the port only ever pulls low and never drives the clock
   assign link.d_sda_o  = 1'b0;
   assign link.d_sda_oe = oe_q;
   assign host_wr_stb   = stb_q;
   assign host_wr_addr  = waddr_q;
   assign host_wr_data  = wdata_q;

endmodule : accel_slave_port

// file: bench/accel_link_chk.sv
// Concurrent checks on the wires between serial host and slave port
`timescale 1ns/1ns
module accel_link_chk (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic cs_n,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic d_sda_o,
   input  wire logic d_sda_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // -----------------------------
   // Sequences
   // -----------------------------
   // Select low long enough for the synchronisers to see it
   sequence spi_held;
      (!cs_n)[*5];
   endsequence
   sequence stop_seen;
      cs_n && scl && $rose(sda);
   endsequence
   a_pull_low_only: assert property ($rose(d_sda_oe) |-> !d_sda_o && !scl && cs_n)
      else $error("device drove data high");
   a_spi_release: assert property (spi_held |-> !d_sda_oe)
      else $error("device holds data while select low");
   a_spi_gap_hold: assert property ($rose(cs_n) |-> cs_n[*2])
      else $error("select gap too short");
   a_sclk_high_min: assert property (!cs_n && $rose(scl) |-> scl[*2])
      else $error("serial clock high phase short");
   a_sclk_low_min: assert property (!cs_n && $fell(scl) |-> (!scl)[*2])
      else $error("serial clock low phase short");
   a_scl_high_time: assert property (cs_n && $rose(scl) |-> scl[*6])
      else $error("bus clock high time short");
   a_ack_on_low: assert property (cs_n && $changed(d_sda_oe) |-> !scl)
      else $error("device moved data while clock high");
   a_bus_free_gap: assert property (stop_seen |=> (sda || !cs_n)[*6])
      else $error("start too soon after stop");
endmodule : accel_link_chk

// file: bench/accel_serial_slave_port_tb.sv
// Bench joining the serial host and the slave port across the link
`timescale 1ns/1ns
module accel_serial_slave_port_tb;
   import accel_link_pkg::*;
   logic             clk, arst_n, slave_address_select_pin, local_we, host_wr_stb;
   logic             req_valid, req_ready, req_read, req_fast, req_spi;
   logic             wr_take, rd_valid, done, nack;
   logic [PTR_W-1:0] local_addr, host_wr_addr;
   logic [7:0]       local_wdata, host_wr_data, req_reg, wr_data, rd_data;
   logic [6:0]       req_dev;
   logic [2:0]       req_len;
   logic [7:0]       wb [8];
   logic [7:0]       rb [8];
   logic [7:0]       hd [8];
   logic [7:0]       ha [8];
   int               wi, ri, hi, num_errors, n_compared, cyc;
   accel_link_if link ();
   accel_slave_port accel_slave_port_inst (.clk, .arst_n, .link(link), .slave_address_select_pin,
      .local_we, .local_addr, .local_wdata, .host_wr_stb, .host_wr_addr, .host_wr_data);
   accel_serial_host accel_serial_host_inst (.clk, .arst_n, .link(link), .req_valid, .req_ready,
      .req_read, .req_fast, .req_spi, .req_dev, .req_reg, .req_len, .wr_data, .wr_take, .rd_data,
      .rd_valid, .done, .nack);
   accel_link_chk accel_link_chk_inst (.clk(clk), .arst_n(arst_n), .cs_n(link.cs_n), .scl(link.scl),
      .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Captures act like flops so they see pre-edge values
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wr_take === 1'b1) begin
         wi = wi + 1;
         wr_data <= wb[wi%8];
      end
      if (rd_valid === 1'b1) begin
         rb[ri%8] = rd_data;
         ri++;
      end
      if (host_wr_stb === 1'b1) begin
         ha[hi%8] = 8'(host_wr_addr);
         hd[hi%8] = host_wr_data;
         hi++;
      end
      // Ceiling sits well above the longest standard-rate run; last so nothing follows the finish
      if (cyc == 40000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic rd, fast, spi, input logic [6:0] dev, input logic [7:0] rg, input int n);
      @(posedge clk);
      req_read <= rd;
      req_fast <= fast;
      req_spi <= spi;
      req_dev <= dev;
      req_reg <= rg;
      req_len <= 3'(n - 1);
      wr_data <= wb[0];
      wi = 0;
      ri = 0;
      hi = 0;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      check(8'(req_ready), 8'h00);
      // Bounded by the global cycle ceiling
      do @(negedge clk); while (done !== 1'b1);
      check(8'(req_ready), 8'h01);
      if (rd && !spi) begin
         check(8'(ri), 8'(n));
      end
   endtask : xfer
   task automatic t_high_wrap();
      slave_address_select_pin <= 1'b1;
      wb[0] = 8'hC3;
      wb[1] = 8'h3C;
      xfer(1'b0, 1'b0, 1'b0, 7'h1D, 8'hFF, 2);
      check(8'(hi), 8'h02);
      check(ha[0], 8'h3F);
      check(ha[1], 8'h00);
      check(hd[1], 8'h3C);
      xfer(1'b1, 1'b0, 1'b0, 7'h1D, 8'hFF, 2);
      check(rb[0], 8'hC3);
      check(rb[1], 8'h3C);
      check(8'(nack), 8'h00);
      $display("t_high_wrap finished");
   endtask : t_high_wrap
   task automatic t_low_fast();
      @(posedge clk);
      slave_address_select_pin <= 1'b0;
      local_we <= 1'b1;
      local_addr <= 6'h0F;
      local_wdata <= 8'h5A;
      @(posedge clk);
      local_we <= 1'b0;
      wb[0] = 8'h96;
      xfer(1'b0, 1'b1, 1'b0, 7'h53, 8'h10, 1);
      check(hd[0], 8'h96);
      xfer(1'b1, 1'b1, 1'b0, 7'h53, 8'h0F, 3);
      check(rb[0], 8'h5A);
      check(rb[1], 8'h96);
      check(rb[2], 8'h00);
      $display("t_low_fast finished");
   endtask : t_low_fast
   task automatic t_wrong_addr();
      xfer(1'b0, 1'b1, 1'b0, 7'h1D, 8'h10, 1);
      check(8'(nack), 8'h01);
      check(8'(hi), 8'h00);
      $display("t_wrong_addr finished");
   endtask : t_wrong_addr
   task automatic t_spi_ignored();
      @(posedge clk);
      slave_address_select_pin <= 1'b1;
      wb[0] = 8'hE1;
      wb[1] = 8'h1E;
      xfer(1'b0, 1'b0, 1'b1, 7'h1D, 8'h05, 2);
      check(8'(hi), 8'h00);
      xfer(1'b1, 1'b1, 1'b0, 7'h1D, 8'h05, 1);
      check(rb[0], 8'h00);
      $display("t_spi_ignored finished");
   endtask : t_spi_ignored
   task automatic conclude();
      $display("compared=%0d errors=%0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      {arst_n, slave_address_select_pin, local_we, req_valid, req_read, req_fast, req_spi} = '0;
      {local_addr, local_wdata, req_dev, req_reg, req_len, wr_data} = '0;
      {wi, ri, hi, num_errors, n_compared, cyc} = '0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_high_wrap();
      t_low_fast();
      t_wrong_addr();
      t_spi_ignored();
      conclude();
   end
endmodule : accel_serial_slave_port_tb
